/* File: bto_mem.sv */
// small memory with registered read data
`timescale 1ns/1ps
module bto_mem #(
  parameter int W = 74,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 arst_n_in,
  // write side
  input  wire logic                 wr_en_in,
  input  wire logic [$clog2(D)-1:0] wr_addr_in,
  input  wire logic [W-1:0]         wr_data_in,
  // read side
  input  wire logic [$clog2(D)-1:0] rd_addr_in,
  output logic      [W-1:0]         rd_data_out
);

  logic [W-1:0] mem [D];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : bto_mem

/* File: bto_path.sv */
// one direction of the bridge: posted write queue, delayed transaction queue, target arbiter
`timescale 1ns/1ps
module bto_path #(
  parameter int PW_DEPTH = bto_pkg::PW_DEPTH_DEF,
  parameter int DT_DEPTH = bto_pkg::DT_DEPTH_DEF
) (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        arst_n_in,
  // initiator bus side
  input  wire bto_pkg::bto_req_s           init_req_in,
  output bto_pkg::bto_resp_s               init_resp_out,
  // target bus side
  output bto_pkg::bto_req_s                tgt_req_out,
  input  wire bto_pkg::bto_ack_s           tgt_ack_in,
  // posted write progress of this direction
  output logic [bto_pkg::SEQ_W-1:0]        pw_enq_cnt_out,
  output logic [bto_pkg::SEQ_W-1:0]        pw_done_cnt_out,
  // posted write progress of the reverse direction
  input  wire logic [bto_pkg::SEQ_W-1:0]   rev_pw_enq_cnt_in,
  input  wire logic [bto_pkg::SEQ_W-1:0]   rev_pw_done_cnt_in
);

  localparam int PW_AW = $clog2(PW_DEPTH);
  localparam int DT_IW = (DT_DEPTH > 1) ? $clog2(DT_DEPTH) : 1;
  localparam int TXN_W = $bits(bto_pkg::bto_txn_s);
  localparam logic [PW_AW:0] PW_FULL = PW_AW'(0) + (PW_AW+1)'(PW_DEPTH);

  generate
    if ((PW_DEPTH < 2) || ((PW_DEPTH & (PW_DEPTH - 1)) != 0)) begin : g_bad_pw
      $error("posted write depth must be a power of two of at least two");
    end
    if ((DT_DEPTH < 1) || (DT_DEPTH > 16)) begin : g_bad_dt
      $error("delayed queue depth must lie between one and sixteen");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [PW_AW-1:0]          pw_wr_ptr;
  logic [PW_AW-1:0]          pw_rd_ptr;
  logic [PW_AW:0]            pw_cnt;
  logic                      pw_seen;
  logic [bto_pkg::SEQ_W-1:0] pw_enq_cnt;
  logic [bto_pkg::SEQ_W-1:0] pw_done_cnt;
  logic [TXN_W-1:0]          pw_head;

  bto_pkg::bto_slot_e        slot_state [DT_DEPTH];
  bto_pkg::bto_txn_s         slot_txn   [DT_DEPTH];
  logic [bto_pkg::SEQ_W-1:0] slot_tag   [DT_DEPTH];
  logic [bto_pkg::SEQ_W-1:0] slot_rtag  [DT_DEPTH];
  logic [31:0]               slot_rdata [DT_DEPTH];
  logic                      slot_rpar  [DT_DEPTH];

  bto_pkg::bto_tgt_e         tgt_state;
  logic [DT_IW-1:0]          tgt_slot;
  logic                      last_pw;

  ////////////////////////////////////////////////////////////////////////////
  // ingress classification and delayed queue search
  logic             req_posted;
  logic             req_delayed;
  logic             pw_push;
  logic             hit;
  logic [DT_IW-1:0] hit_idx;
  logic             free_any;
  logic [DT_IW-1:0] free_idx;
  logic             elig_any;
  logic [DT_IW-1:0] elig_idx;
  logic             hit_ready;

  assign req_posted  = init_req_in.valid && bto_pkg::cmd_is_posted(init_req_in.txn.cmd);
  assign req_delayed = init_req_in.valid &&
                       (bto_pkg::cmd_is_dwrite(init_req_in.txn.cmd) ||
                        bto_pkg::cmd_is_read(init_req_in.txn.cmd));
  // only fullness can refuse a posted write, never the delayed queue
  assign pw_push     = req_posted && (pw_cnt != PW_FULL);

  // a repeat must match command, address and byte enables; delayed write data must match too
  function automatic logic txn_match(input bto_pkg::bto_txn_s a, input bto_pkg::bto_txn_s b);
    logic same;
    same = (a.cmd == b.cmd) && (a.addr == b.addr) && (a.be == b.be);
    if (bto_pkg::cmd_is_dwrite(a.cmd)) begin
      same = same && (a.data == b.data);
    end
    return same;
  endfunction : txn_match

  always_comb begin
    hit      = 1'b0;
    hit_idx  = '0;
    free_any = 1'b0;
    free_idx = '0;
    elig_any = 1'b0;
    elig_idx = '0;
    for (int i = DT_DEPTH - 1; i >= 0; i--) begin
      if (slot_state[i] != bto_pkg::SLOT_FREE && txn_match(slot_txn[i], init_req_in.txn)) begin
        hit     = 1'b1;
        hit_idx = DT_IW'(i);
      end
      if (slot_state[i] == bto_pkg::SLOT_FREE) begin
        free_any = 1'b1;
        free_idx = DT_IW'(i);
      end
      // delayed requests wait behind earlier posted writes
      if (slot_state[i] == bto_pkg::SLOT_WAIT &&
          bto_pkg::seq_reached(pw_done_cnt, slot_tag[i])) begin
        elig_any = 1'b1;
        elig_idx = DT_IW'(i);
      end
    end
  end

  // read data released only after reverse posted writes ahead of it; writes pass freely
  assign hit_ready = hit && slot_state[hit_idx] == bto_pkg::SLOT_DONE &&
                     (bto_pkg::cmd_is_dwrite(slot_txn[hit_idx].cmd) ||
                      bto_pkg::seq_reached(rev_pw_done_cnt_in, slot_rtag[hit_idx]));

  ////////////////////////////////////////////////////////////////////////////
  // target side arbitration
  logic pw_ready;
  logic grant_pw;
  logic grant_dt;
  logic ack_ok;
  logic pw_pop;

  assign pw_ready = (pw_cnt != '0) && pw_seen;
  // alternate when both queues have work, so each gets regular turns
  assign grant_pw = (tgt_state == bto_pkg::TGT_IDLE) && pw_ready &&
                    (!elig_any || !last_pw);
  assign grant_dt = (tgt_state == bto_pkg::TGT_IDLE) && elig_any && !grant_pw;
  // a target retry fixes no order; only a real end does
  assign ack_ok   = tgt_ack_in.valid && !tgt_ack_in.retry;
  assign pw_pop   = ack_ok && (tgt_state == bto_pkg::TGT_PW);

  ////////////////////////////////////////////////////////////////////////////
  // posted write queue
  bto_mem #(
    .W (TXN_W),
    .D (PW_DEPTH)
  ) u_pw_mem (
    .clk_in      (clk_in),
    .arst_n_in   (arst_n_in),
    .wr_en_in    (pw_push),
    .wr_addr_in  (pw_wr_ptr),
    .wr_data_in  (init_req_in.txn),
    .rd_addr_in  (pw_rd_ptr),
    .rd_data_out (pw_head)
  );

  // every accepted write gets its own entry and leaves unchanged, in order
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pw_wr_ptr  <= '0;
      pw_enq_cnt <= '0;
    end else if (pw_push) begin
      pw_wr_ptr  <= pw_wr_ptr + PW_AW'(1);
      pw_enq_cnt <= pw_enq_cnt + bto_pkg::SEQ_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pw_rd_ptr   <= '0;
      pw_done_cnt <= '0;
    end else if (pw_pop) begin
      pw_rd_ptr   <= pw_rd_ptr + PW_AW'(1);
      pw_done_cnt <= pw_done_cnt + bto_pkg::SEQ_W'(1);
    end
  end

  // head data is valid one cycle after the read pointer settles
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pw_cnt  <= '0;
      pw_seen <= 1'b0;
    end else begin
      pw_cnt  <= pw_cnt + (PW_AW+1)'(pw_push) - (PW_AW+1)'(pw_pop);
      pw_seen <= (pw_cnt != '0) && !pw_pop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delayed transaction queue
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < DT_DEPTH; i++) begin
        slot_state[i] <= bto_pkg::SLOT_FREE;
      end
    end else begin
      if (req_delayed && !hit && free_any) begin
        slot_state[free_idx] <= bto_pkg::SLOT_WAIT;
      end
      if (req_delayed && hit_ready) begin
        slot_state[hit_idx] <= bto_pkg::SLOT_FREE;
      end
      if (grant_dt) begin
        slot_state[elig_idx] <= bto_pkg::SLOT_BUSY;
      end
      if (tgt_ack_in.valid && tgt_state == bto_pkg::TGT_DT) begin
        if (tgt_ack_in.retry) begin
          slot_state[tgt_slot] <= bto_pkg::SLOT_WAIT;
        end else begin
          slot_state[tgt_slot] <= bto_pkg::SLOT_DONE;
        end
      end
    end
  end

  // capture every field of the request, including parity
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < DT_DEPTH; i++) begin
        slot_txn[i] <= '0;
        slot_tag[i] <= '0;
      end
    end else if (req_delayed && !hit && free_any) begin
      slot_txn[free_idx] <= init_req_in.txn;
      slot_tag[free_idx] <= pw_enq_cnt;
    end
  end

  // hold the response or read data for the initiator's repeat
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < DT_DEPTH; i++) begin
        slot_rdata[i] <= '0;
        slot_rpar[i]  <= 1'b0;
        slot_rtag[i]  <= '0;
      end
    end else if (tgt_ack_in.valid && !tgt_ack_in.retry && tgt_state == bto_pkg::TGT_DT) begin
      slot_rdata[tgt_slot] <= tgt_ack_in.rdata;
      slot_rpar[tgt_slot]  <= tgt_ack_in.rpar;
      slot_rtag[tgt_slot]  <= rev_pw_enq_cnt_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // initiator answer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      init_resp_out <= '{code: bto_pkg::RESP_NONE, rdata: 32'h0, rpar: 1'b0};
    end else begin
      init_resp_out.code  <= bto_pkg::RESP_NONE;
      init_resp_out.rdata <= 32'h0;
      init_resp_out.rpar  <= 1'b0;
      if (req_posted) begin
        init_resp_out.code <= pw_push ? bto_pkg::RESP_ACCEPT : bto_pkg::RESP_RETRY;
      end else if (req_delayed) begin
        if (hit_ready) begin
          init_resp_out.code  <= bto_pkg::RESP_DONE;
          init_resp_out.rdata <= slot_rdata[hit_idx];
          init_resp_out.rpar  <= slot_rpar[hit_idx];
        end else begin
          init_resp_out.code <= bto_pkg::RESP_RETRY;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remember which queue went last so that both get turns
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      last_pw <= 1'b0;
    end else if (grant_pw) begin
      last_pw <= 1'b1;
    end else if (grant_dt) begin
      last_pw <= 1'b0;
    end
  end

  // target bus master
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tgt_state   <= bto_pkg::TGT_IDLE;
      tgt_slot    <= '0;
      tgt_req_out <= '0;
    end else begin
      case (tgt_state)
        bto_pkg::TGT_IDLE: begin
          if (grant_pw) begin
            tgt_state   <= bto_pkg::TGT_PW;
            tgt_req_out <= {1'b1, pw_head};
          end else if (grant_dt) begin
            tgt_state   <= bto_pkg::TGT_DT;
            tgt_slot    <= elig_idx;
            tgt_req_out <= {1'b1, slot_txn[elig_idx]};
          end
        end
        bto_pkg::TGT_PW, bto_pkg::TGT_DT: begin
          if (tgt_ack_in.valid) begin
            tgt_state         <= bto_pkg::TGT_IDLE;
            tgt_req_out.valid <= 1'b0;
          end
        end
        default: begin
          tgt_state   <= bto_pkg::TGT_IDLE;
          tgt_req_out <= '0;
        end
      endcase
    end
  end

  // each direction counts only its own writes, independent of the other
  assign pw_enq_cnt_out  = pw_enq_cnt;
  assign pw_done_cnt_out = pw_done_cnt;

endmodule : bto_path

/* File: bto_path_checker.sv */
// port assertions of one bridge ordering path
`timescale 1ns/1ps
module bto_path_checker (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      arst_n_in,
  // initiator side
  input  wire bto_pkg::bto_req_s         init_req_in,
  input  wire bto_pkg::bto_resp_s        init_resp_out,
  // target side
  input  wire bto_pkg::bto_req_s         tgt_req_out,
  input  wire bto_pkg::bto_ack_s         tgt_ack_in,
  // progress counts
  input  wire logic [bto_pkg::SEQ_W-1:0] pw_enq_cnt_out,
  input  wire logic [bto_pkg::SEQ_W-1:0] pw_done_cnt_out,
  input  wire logic [bto_pkg::SEQ_W-1:0] rev_pw_enq_cnt_in,
  input  wire logic [bto_pkg::SEQ_W-1:0] rev_pw_done_cnt_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic ip;
  logic tp;
  assign ip = init_req_in.txn.cmd inside {bto_pkg::CMD_MEM_WR, bto_pkg::CMD_MEM_WI};
  assign tp = tgt_req_out.txn.cmd inside {bto_pkg::CMD_MEM_WR, bto_pkg::CMD_MEM_WI};
  sequence s_wait;
    tgt_req_out.valid && !tgt_ack_in.valid;
  endsequence
  sequence s_fin;
    tgt_req_out.valid && tgt_ack_in.valid && !tgt_ack_in.retry && tp;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_post_taken: assert property (init_req_in.valid && ip |=>
    (init_resp_out.code == bto_pkg::RESP_ACCEPT && pw_enq_cnt_out == $past(pw_enq_cnt_out) + 16'h1)
    || (init_resp_out.code == bto_pkg::RESP_RETRY && $stable(pw_enq_cnt_out)))
    else $error("posted write answer or count wrong");
  a_enq_quiet: assert property (!(init_req_in.valid && ip) |=> $stable(pw_enq_cnt_out))
    else $error("posted count moved without a posted write");
  a_nonpost_held: assert property (
    init_req_in.valid && !ip |=> init_resp_out.code != bto_pkg::RESP_ACCEPT)
    else $error("non-posted request was accepted as posted");
  a_idle_quiet: assert property (
    !init_req_in.valid |=> init_resp_out.code == bto_pkg::RESP_NONE)
    else $error("answer without a request");
  a_req_hold: assert property (s_wait |=> tgt_req_out.valid && $stable(tgt_req_out.txn))
    else $error("target request changed before its answer");
  a_req_release: assert property (
    tgt_req_out.valid && tgt_ack_in.valid |=> !tgt_req_out.valid)
    else $error("target request not released after answer");
  a_done_step: assert property (
    s_fin |=> pw_done_cnt_out == $past(pw_done_cnt_out) + 16'h1)
    else $error("posted done count did not advance");
  a_done_quiet: assert property (
    !(tgt_req_out.valid && tgt_ack_in.valid && !tgt_ack_in.retry && tp) |=> $stable(pw_done_cnt_out))
    else $error("posted done count moved without completion");
  a_rdata_clear: assert property (
    init_resp_out.code != bto_pkg::RESP_DONE |-> init_resp_out.rdata == 32'h0)
    else $error("read data shown without completion");
endmodule : bto_path_checker

bind bto_path bto_path_checker bto_path_checker_i (.clk_in, .arst_n_in, .init_req_in,
  .init_resp_out, .tgt_req_out, .tgt_ack_in, .pw_enq_cnt_out, .pw_done_cnt_out,
  .rev_pw_enq_cnt_in, .rev_pw_done_cnt_in);

/* File: bto_path_test.sv */
// self-checking testbench of one bridge ordering path
`timescale 1ns/1ps
module bto_path_test;
  localparam int PWD = 4;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  bto_pkg::bto_req_s  init_req;
  bto_pkg::bto_resp_s resp;
  bto_pkg::bto_req_s  tgt_req;
  bto_pkg::bto_ack_s  ack;
  logic [15:0] enq, done, rev_enq, rev_done;
  logic [3:0]  wait_c;
  logic        retry_c;
  int          fail_count = 0;
  int          n_compared = 0;
  always #4 clk_in = ~clk_in;
  bto_path #(.PW_DEPTH(PWD), .DT_DEPTH(4)) bto_path_i (.clk_in, .arst_n_in,
    .init_req_in(init_req), .init_resp_out(resp), .tgt_req_out(tgt_req), .tgt_ack_in(ack),
    .pw_enq_cnt_out(enq), .pw_done_cnt_out(done),
    .rev_pw_enq_cnt_in(rev_enq), .rev_pw_done_cnt_in(rev_done));
  bto_tgt_model bto_tgt_model_i (.clk_in, .arst_n_in, .wait_in(wait_c), .retry_in(retry_c),
    .req_in(tgt_req), .ack_out(ack));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : cmp
  // one request per call, held across one rising edge
  task automatic req(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be,
                     output bto_pkg::bto_resp_e r);
    init_req.valid    = 1'b1;
    init_req.txn.cmd  = c;
    init_req.txn.addr = a;
    init_req.txn.data = {a[27:0], be};
    init_req.txn.be   = be;
    init_req.txn.apar = ^a;
    init_req.txn.dpar = ^be;
    @(negedge clk_in);
    r = resp.code;
  endtask : req
  task automatic wait_log(input int n);
    for (int i = 0; i < 300 && bto_tgt_model_i.log_q.size() < n; i++) @(negedge clk_in);
    if (bto_tgt_model_i.log_q.size() < n) begin
      fail_count++;
      $display("ERROR %0t target traffic missing", $time);
      give_verdict();
    end
  endtask : wait_log
  task automatic chk_log(input int k, input logic [3:0] c, input logic [31:0] a,
                         input logic [3:0] be);
    bto_pkg::bto_txn_s t;
    t = bto_tgt_model_i.log_q[k];
    cmp({t.cmd, t.be}, {c, be}, "forwarded command or enables");
    cmp(t.addr, a, "forwarded address");
    cmp(t.data, {a[27:0], be}, "forwarded data");
    cmp({t.apar, t.dpar}, {^a, ^be}, "forwarded parity");
  endtask : chk_log
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_other;
    bto_pkg::bto_resp_e r;
    for (int i = 0; i < 16; i++) begin
      if (!(i inside {2, 3, 6, 7, 10, 11, 12, 14, 15})) begin
        req(i[3:0], 32'h40, 4'hF, r);
        cmp(r, bto_pkg::RESP_NONE, "unclassified command answered");
      end
    end
    init_req.valid = 1'b0;
    @(negedge clk_in);
  endtask : t_other
  // same address, distinct masks, back to back, slow target
  task automatic t_posted;
    bto_pkg::bto_resp_e r;
    int n0;
    logic [15:0] e0;
    n0 = bto_tgt_model_i.log_q.size();
    e0 = enq;
    wait_c = 4'h3;
    for (int i = 0; i < 4; i++) begin
      req(i[0] ? bto_pkg::CMD_MEM_WI : bto_pkg::CMD_MEM_WR, 32'h100, 4'h1 << i, r);
      cmp(r, bto_pkg::RESP_ACCEPT, "posted write not accepted");
    end
    init_req.valid = 1'b0;
    cmp(enq, e0 + 16'h4, "posted count");
    wait_log(n0 + 4);
    for (int i = 0; i < 4; i++)
      chk_log(n0 + i, i[0] ? bto_pkg::CMD_MEM_WI : bto_pkg::CMD_MEM_WR,
              32'h100, 4'h1 << i);
  endtask : t_posted
  // fill under target retry until refused, then drain
  task automatic t_full;
    bto_pkg::bto_resp_e r;
    int n0;
    logic [15:0] e0, d0;
    n0 = bto_tgt_model_i.log_q.size();
    e0 = enq;
    wait_c = 4'h0;
    retry_c = 1'b1;
    for (int i = 0; i <= PWD; i++) begin
      req(bto_pkg::CMD_MEM_WR, 32'h200 + 4 * i, 4'hF, r);
      cmp(r, i < PWD ? bto_pkg::RESP_ACCEPT : bto_pkg::RESP_RETRY,
          "posted when full");
    end
    init_req.valid = 1'b0;
    // the last write of the previous scenario has finished by now
    d0 = done;
    repeat (20) @(negedge clk_in);
    cmp(done, d0, "retried writes counted done");
    retry_c = 1'b0;
    wait_log(n0 + PWD);
    for (int i = 0; i < PWD; i++)
      chk_log(n0 + i, bto_pkg::CMD_MEM_WR, 32'h200 + 4 * i, 4'hF);
    cmp(enq, e0 + PWD, "refused write stored");
  endtask : t_full
  task automatic poll(input logic [3:0] c, input logic [31:0] a, output bto_pkg::bto_resp_e r);
    for (int i = 0; i < 40; i++) begin
      req(c, a, 4'hF, r);
      if (r != bto_pkg::RESP_RETRY) break;
    end
    init_req.valid = 1'b0;
  endtask : poll
  // posted write then delayed request to the same place; reverse writes outstanding
  task automatic t_delayed(input logic [3:0] c, input logic rd);
    bto_pkg::bto_resp_e r;
    int n0;
    logic [31:0] a;
    @(negedge clk_in);
    n0 = bto_tgt_model_i.log_q.size();
    a = {24'h0, c, 4'h0};
    wait_c = 4'h2;
    rev_enq = rev_enq + 16'h1;
    req(bto_pkg::CMD_MEM_WR, a, 4'hF, r);
    req(c, a, 4'hF, r);
    cmp(r, bto_pkg::RESP_RETRY, "delayed first answer");
    // a later posted write is taken while the delayed request is pending
    req(bto_pkg::CMD_MEM_WR, a + 32'h4, 4'hF, r);
    cmp(r, bto_pkg::RESP_ACCEPT, "posted write refused behind delayed");
    init_req.valid = 1'b0;
    wait_log(n0 + 3);
    chk_log(n0, bto_pkg::CMD_MEM_WR, a, 4'hF);
    chk_log(n0 + 1, c, a, 4'hF);
    chk_log(n0 + 2, bto_pkg::CMD_MEM_WR, a + 32'h4, 4'hF);
    if (rd) begin
      for (int i = 0; i < 4; i++) begin
        req(c, a, 4'hF, r);
        cmp(r, bto_pkg::RESP_RETRY, "read completed past reverse writes");
      end
      rev_done = rev_enq;
    end
    poll(c, a, r);
    cmp(r, bto_pkg::RESP_DONE, "delayed completion");
    if (rd) cmp(resp.rdata, ~a, "read data");
    if (rd) cmp(resp.rpar, ^a, "read parity");
    rev_done = rev_enq;
  endtask : t_delayed
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    init_req = '0;
    rev_enq = 16'h0;
    rev_done = 16'h0;
    wait_c = 4'h0;
    retry_c = 1'b0;
    repeat (8) @(negedge clk_in);
    arst_n_in = 1'b1;
    @(negedge clk_in);
    t_other();
    t_posted();
    t_full();
    t_delayed(bto_pkg::CMD_IO_RD, 1'b1);
    t_delayed(bto_pkg::CMD_MEM_RD, 1'b1);
    t_delayed(bto_pkg::CMD_CFG_RD, 1'b1);
    t_delayed(bto_pkg::CMD_MEM_RDM, 1'b1);
    t_delayed(bto_pkg::CMD_MEM_RDL, 1'b1);
    t_delayed(bto_pkg::CMD_IO_WR, 1'b0);
    t_delayed(bto_pkg::CMD_CFG_WR, 1'b0);
    give_verdict();
  end
endmodule : bto_path_test

/* File: bto_pkg.sv */
// shared constants, types and helpers of the bridge transaction ordering block
package bto_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus command codes
  localparam logic [3:0] CMD_IO_RD   = 4'h2;
  localparam logic [3:0] CMD_IO_WR   = 4'h3;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'hA;
  localparam logic [3:0] CMD_CFG_WR  = 4'hB;
  localparam logic [3:0] CMD_MEM_RDM = 4'hC;
  localparam logic [3:0] CMD_MEM_RDL = 4'hE;
  localparam logic [3:0] CMD_MEM_WI  = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int PW_DEPTH_DEF = 8;
  localparam int DT_DEPTH_DEF = 4;
  localparam int SEQ_W        = 16;

  ////////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [1:0] {
    RESP_NONE   = 2'b00,
    RESP_ACCEPT = 2'b01,
    RESP_RETRY  = 2'b10,
    RESP_DONE   = 2'b11
  } bto_resp_e;

  typedef enum logic [1:0] {
    SLOT_FREE = 2'b00,
    SLOT_WAIT = 2'b01,
    SLOT_BUSY = 2'b10,
    SLOT_DONE = 2'b11
  } bto_slot_e;

  typedef enum logic [1:0] {
    TGT_IDLE = 2'b00,
    TGT_PW   = 2'b01,
    TGT_DT   = 2'b10
  } bto_tgt_e;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
    logic        apar;
    logic        dpar;
  } bto_txn_s;

  typedef struct packed {
    logic     valid;
    bto_txn_s txn;
  } bto_req_s;

  typedef struct packed {
    bto_resp_e   code;
    logic [31:0] rdata;
    logic        rpar;
  } bto_resp_s;

  typedef struct packed {
    logic        valid;
    logic        retry;
    logic [31:0] rdata;
    logic        rpar;
  } bto_ack_s;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic cmd_is_posted(input logic [3:0] cmd);
    return (cmd == CMD_MEM_WR) || (cmd == CMD_MEM_WI);
  endfunction : cmd_is_posted

  function automatic logic cmd_is_dwrite(input logic [3:0] cmd);
    return (cmd == CMD_IO_WR) || (cmd == CMD_CFG_WR);
  endfunction : cmd_is_dwrite

  function automatic logic cmd_is_read(input logic [3:0] cmd);
    return (cmd == CMD_IO_RD) || (cmd == CMD_MEM_RD) || (cmd == CMD_CFG_RD) ||
           (cmd == CMD_MEM_RDM) || (cmd == CMD_MEM_RDL);
  endfunction : cmd_is_read

  // true once the done count has caught up with a captured enqueue count
  function automatic logic seq_reached(input logic [SEQ_W-1:0] done,
                                       input logic [SEQ_W-1:0] tag);
    logic [SEQ_W-1:0] diff;
    diff = done - tag;
    return !diff[SEQ_W-1];
  endfunction : seq_reached

endpackage : bto_pkg

/* File: bto_tgt_model.sv */
// target bus model: answers after a set wait, with or without retry, logs completions
`timescale 1ns/1ps
module bto_tgt_model (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // bench control
  input  wire logic [3:0]        wait_in,
  input  wire logic              retry_in,
  // target bus
  input  wire bto_pkg::bto_req_s req_in,
  output bto_pkg::bto_ack_s      ack_out
);
  bto_pkg::bto_txn_s log_q[$];
  logic [3:0]        cnt;
  logic              hold;
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_out <= '0;
      cnt     <= 4'h0;
      hold    <= 1'b0;
    end else begin
      ack_out.valid <= 1'b0;
      ack_out.retry <= 1'b0;
      // data lines scramble while no answer is driven
      ack_out.rdata <= ~ack_out.rdata;
      ack_out.rpar  <= ~ack_out.rpar;
      if (!req_in.valid) begin
        hold <= 1'b0;
        cnt  <= 4'h0;
      end else if (!hold && cnt == wait_in) begin
        ack_out.valid <= 1'b1;
        ack_out.retry <= retry_in;
        ack_out.rdata <= ~req_in.txn.addr;
        ack_out.rpar  <= ^req_in.txn.addr;
        hold          <= 1'b1;
        if (!retry_in) log_q.push_back(req_in.txn);
      end else if (!hold) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : bto_tgt_model
